// [design/ifc_pkg.sv]
// Constants for the inverter frequency command block
package ifc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 25_000_000;
  localparam int CTRL_PERIOD_US  = 1000;
  localparam int CTRL_CYCLES     = CLK_HZ / 1_000_000 * CTRL_PERIOD_US;
  localparam int GATE_MS         = 100;
  localparam int GATE_CYCLES     = CLK_HZ / 1000 * GATE_MS;
  localparam int STALL_MS        = 100;
  localparam int STALL_PERIODS   = STALL_MS * 1000 / CTRL_PERIOD_US;
  localparam int PER_TENTH_S     = 100_000 / CTRL_PERIOD_US;
  localparam int SLIP_TC_ZERO    = 20;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_PSCALE = 8'h04;
  localparam logic [7:0] ADDR_LIMIT  = 8'h08;
  localparam logic [7:0] ADDR_FREQ   = 8'h0C;
  localparam logic [7:0] ADDR_FMIN   = 8'h10;
  localparam logic [7:0] ADDR_ADJ    = 8'h14;
  localparam logic [7:0] ADDR_RAMP   = 8'h18;
  localparam logic [7:0] ADDR_MOTOR  = 8'h1C;
  localparam logic [7:0] ADDR_SLIPTC = 8'h20;
  localparam logic [7:0] ADDR_STAT   = 8'h24;
  localparam logic [7:0] ADDR_REFOUT = 8'h28;
  // ----------------------------------------------------------------
  // CTRL fields
  // ----------------------------------------------------------------
  localparam int C_SRC   = 0;
  localparam int C_METH  = 4;
  localparam int C_DSTL  = 8;
  localparam int C_AUTO  = 9;
  localparam int C_RSEL  = 10;
  localparam int C_TSET2 = 11;
  localparam int C_FN1   = 12;
  localparam int C_FN2   = 16;
  localparam int C_RUNS  = 20;
  localparam int C_SWRUN = 22;
  localparam int C_SWREV = 23;
  localparam logic [23:0] CTRL_RST = 24'h021001;
  // ----------------------------------------------------------------
  // Setting values and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0]  SRC_I420    = 4'h3;
  localparam logic [3:0]  SRC_I020    = 4'h4;
  localparam logic [3:0]  SRC_PULSE   = 4'h6;
  localparam logic [3:0]  FN_FWD      = 4'h1;
  localparam logic [3:0]  FN_REV      = 4'h2;
  localparam logic [1:0]  RUN_TERM    = 2'h1;
  localparam logic [11:0] PSCALE_MIN  = 12'h064;
  localparam logic [11:0] PSCALE_MAX  = 12'hCE4;
  localparam logic [11:0] PSCALE_RST  = 12'h9C4;
  localparam logic [7:0]  ACC_LIM_RST = 8'hAA;
  localparam logic [7:0]  RUN_LIM_RST = 8'hA0;
  localparam logic [7:0]  LIM_OFF     = 8'hC8;
  localparam int          HYST_PCT    = 5;
  localparam logic [7:0]  SLIPTC_RST  = 8'h14;
  localparam logic [9:0]  GAIN_RST    = 10'h064;
  localparam logic [15:0] FMAX_RST    = 16'h0258;
  localparam logic [15:0] FVMAX_RST   = 16'h0258;
  localparam logic [15:0] FMIN_RST    = 16'h000F;
  localparam logic [31:0] RAMP_RST    = 32'h64646464;
  localparam int          ADC_4MA     = 819;
  localparam int          ADC_FULL    = 4095;
  localparam logic [1:0]  RESP_OK     = 2'h0;
  localparam logic [1:0]  RESP_ERR    = 2'h2;
endpackage

// [design/ifc_pulse_meter.sv]
// Pulse-train frequency meter with a fixed gate
`timescale 1ns/100ps
`default_nettype none
module ifc_pulse_meter
  import ifc_pkg::*;
#(
  parameter int GATE = GATE_CYCLES
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Pulse pin
  input  wire logic        pulse_in,
  // Pulses per gate, 10 Hz per count
  output logic [11:0]      count
);
  localparam int GW = $clog2(GATE + 1);
  if (GATE < 2) begin : g_chk
    $error("GATE too small");
  end

  typedef struct packed {
    logic [1:0]    sync;
    logic          prev;
    logic [GW-1:0] gate;
    logic [11:0]   edges;
    logic [11:0]   count;
  } pm_t;
  pm_t s, n;

  always_comb begin
    n = s;
    n.sync = {s.sync[0], pulse_in};
    n.prev = s.sync[1];
    if (s.sync[1] && !s.prev && s.edges != 12'hFFF) begin
      n.edges = s.edges + 12'h001;
    end
    if (s.gate == GW'(GATE - 1)) begin
      n.gate  = '0;
      n.count = n.edges;
      n.edges = '0;
    end else begin
      n.gate = s.gate + GW'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign count = s.count;
endmodule
`default_nettype wire

// [design/ifc_freq_cmd.sv]
// Frequency command: reference select, stall prevention, slip compensation
`timescale 1ns/100ps
`default_nettype none
module ifc_freq_cmd
  import ifc_pkg::*;
#(
  parameter int CTRL_TICKS = CTRL_CYCLES,
  parameter int GATE_TICKS = GATE_CYCLES,
  parameter int INV_RATED  = 100,
  parameter int DC_STALL_V = 380
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Terminals
  input  wire logic [11:0] analog_ref_terminal,
  input  wire logic        multifunction_input_one,
  input  wire logic        multifunction_input_two,
  input  wire logic        pulse_train_in,
  // Measurements
  input  wire logic [11:0] output_current,
  input  wire logic [11:0] dc_bus_voltage,
  input  wire logic        regen_active,
  // Modulator command
  output logic [15:0]      freq_cmd,
  output logic             run_fwd,
  output logic             run_rev
);
  if (CTRL_TICKS < 2 || CTRL_TICKS > 65536 || INV_RATED < 1) begin : g_chk
    $error("Bad parameter");
  end

  typedef struct packed {
    logic [23:0] ctrl;
    logic [11:0] pscale;
    logic [7:0]  acc_lim;
    logic [7:0]  run_lim;
    logic [15:0] fmax;
    logic [15:0] fvmax;
    logic [15:0] fmin;
    logic [9:0]  gain;
    logic [15:0] bias;
    logic [31:0] ramp;
    logic [31:0] motor;
    logic [7:0]  slip_tc;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [1:0]  s1;
    logic [1:0]  s2;
    logic [15:0] tcnt;
    logic [11:0] i_s;
    logic [15:0] fref;
    logic [15:0] fout;
    logic [15:0] comp;
    logic [31:0] slip_acc;
    logic [15:0] fcmd;
    logic        acc_hold;
    logic        run_stall;
    logic [7:0]  stall_cnt;
    logic        fwd;
    logic        rev;
  } ifc_st_t;
  ifc_st_t s, n;

  logic [11:0] pcount;
  logic        tick;
  logic        wr_go;
  int          raw_ref;
  int          slip_tgt;
  int          tgt_q;

  ifc_pulse_meter #(.GATE(GATE_TICKS)) u_ifc_pulse_meter (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pulse_in (pulse_train_in),
    .count    (pcount)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] wmerge(logic [31:0] o, logic [31:0] d,
                                         logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int k = 0; k < 4; k++) begin
      if (be[k]) begin
        r[8*k +: 8] = d[8*k +: 8];
      end
    end
    return r;
  endfunction

  function automatic int rstep(logic [15:0] fm, logic [7:0] t);
    int st;
    st = (t == 8'h00) ? int'(fm) : int'(fm) / (int'(t) * PER_TENTH_S);
    return (st < 1) ? 1 : st;
  endfunction

  function automatic int lowered(logic [7:0] lim, logic [15:0] fv,
                                 logic [15:0] fo);
    if (fo > fv && fv != 16'h0000) begin
      return int'(lim) * int'(fv) / int'(fo);
    end
    return int'(lim);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] wv;
    logic [31:0] rd;
    int          a;
    int          pct;
    int          alim;
    int          rlim;
    int          tgt;
    int          nl;
    int          rated;
    int          ast;
    int          dst;
    int          tcn;
    int          c;
    logic        set2;
    logic        term;
    logic        ff;
    logic        rr;
    n       = s;
    wv      = '0;
    rd      = '0;
    a       = 0;
    pct     = 0;
    alim    = 0;
    rlim    = 0;
    tgt     = 0;
    nl      = 0;
    rated   = 0;
    ast     = 0;
    dst     = 0;
    tcn     = 0;
    c       = 0;
    set2    = 1'b0;
    term    = 1'b0;
    ff      = 1'b0;
    rr      = 1'b0;
    raw_ref = 0;
    slip_tgt = 0;
    tick    = (s.tcnt == 16'(CTRL_TICKS - 1));
    n.tcnt  = tick ? 16'h0000 : s.tcnt + 16'h0001;
    n.s1    = {s.s1[0], multifunction_input_one};
    n.s2    = {s.s2[0], multifunction_input_two};

    // Register writes
    wr_go = !s.bvalid && awvalid && wvalid;
    if (wr_go) begin
      n.bvalid = 1'b1;
      n.bresp  = RESP_OK;
      if (awaddr == ADDR_CTRL) begin
        wv = wmerge({8'h00, s.ctrl}, wdata, wstrb);
        n.ctrl = wv[23:0];
      end else if (awaddr == ADDR_PSCALE) begin
        wv = wmerge({20'h00000, s.pscale}, wdata, wstrb);
        if (wv[31:12] == '0 && wv[11:0] >= PSCALE_MIN && wv[11:0] <= PSCALE_MAX) begin
          n.pscale = wv[11:0];
        end
      end else if (awaddr == ADDR_LIMIT) begin
        wv = wmerge({16'h0000, s.run_lim, s.acc_lim}, wdata, wstrb);
        n.acc_lim = (wv[7:0] > LIM_OFF) ? LIM_OFF : wv[7:0];
        n.run_lim = (wv[15:8] > LIM_OFF) ? LIM_OFF : wv[15:8];
      end else if (awaddr == ADDR_FREQ) begin
        wv = wmerge({s.fvmax, s.fmax}, wdata, wstrb);
        n.fmax  = wv[15:0];
        n.fvmax = wv[31:16];
      end else if (awaddr == ADDR_FMIN) begin
        wv = wmerge({16'h0000, s.fmin}, wdata, wstrb);
        n.fmin = wv[15:0];
      end else if (awaddr == ADDR_ADJ) begin
        wv = wmerge({s.bias, 6'h00, s.gain}, wdata, wstrb);
        n.gain = wv[9:0];
        n.bias = wv[31:16];
      end else if (awaddr == ADDR_RAMP) begin
        n.ramp = wmerge(s.ramp, wdata, wstrb);
      end else if (awaddr == ADDR_MOTOR) begin
        wv = wmerge(s.motor, wdata, wstrb);
        if (wv[18:12] > 7'h63) begin
          wv[18:12] = 7'h63;
        end
        n.motor = wv;
      end else if (awaddr == ADDR_SLIPTC) begin
        wv = wmerge({24'h000000, s.slip_tc}, wdata, wstrb);
        n.slip_tc = wv[7:0];
      end else begin
        n.bresp = RESP_ERR;
      end
    end else if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end

    // Register reads
    if (!s.rvalid && arvalid) begin
      n.rvalid = 1'b1;
      n.rresp  = RESP_OK;
      if (araddr == ADDR_CTRL) begin
        rd = {8'h00, s.ctrl};
      end else if (araddr == ADDR_PSCALE) begin
        rd = {20'h00000, s.pscale};
      end else if (araddr == ADDR_LIMIT) begin
        rd = {16'h0000, s.run_lim, s.acc_lim};
      end else if (araddr == ADDR_FREQ) begin
        rd = {s.fvmax, s.fmax};
      end else if (araddr == ADDR_FMIN) begin
        rd = {16'h0000, s.fmin};
      end else if (araddr == ADDR_ADJ) begin
        rd = {s.bias, 6'h00, s.gain};
      end else if (araddr == ADDR_RAMP) begin
        rd = s.ramp;
      end else if (araddr == ADDR_MOTOR) begin
        rd = s.motor;
      end else if (araddr == ADDR_SLIPTC) begin
        rd = {24'h000000, s.slip_tc};
      end else if (araddr == ADDR_STAT) begin
        rd = {11'h000, s.rev, s.fwd, s.run_stall, s.acc_hold, s.fcmd != s.fout, s.fout};
      end else if (araddr == ADDR_REFOUT) begin
        rd = {s.comp, s.fref};
      end else begin
        n.rresp = RESP_ERR;
      end
      n.rdata = rd;
    end else if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end

    // Reference source
    if (s.ctrl[C_SRC +: 4] == SRC_I420) begin
      a = (int'(analog_ref_terminal) < ADC_4MA) ? 0 :
          (int'(analog_ref_terminal) - ADC_4MA) * int'(s.fmax) / (ADC_FULL - ADC_4MA);
    end else if (s.ctrl[C_SRC +: 4] == SRC_I020) begin
      a = int'(analog_ref_terminal) * int'(s.fmax) / ADC_FULL;
    end else if (s.ctrl[C_SRC +: 4] == SRC_PULSE) begin
      a = int'(pcount) * int'(s.fmax) / int'(s.pscale);
    end else begin
      a = int'(analog_ref_terminal) * int'(s.fmax) / ADC_FULL;
    end
    raw_ref = a;
    a = a * int'(s.gain) / 100 + int'(s.bias);
    n.fref = (a > int'(s.fmax)) ? s.fmax : 16'(a);

    // Run command
    term = (s.ctrl[C_RUNS +: 2] == RUN_TERM);
    ff = (s.s1[1] && s.ctrl[C_FN1 +: 4] == FN_FWD) ||
         (s.s2[1] && s.ctrl[C_FN2 +: 4] == FN_FWD);
    rr = (s.s1[1] && s.ctrl[C_FN1 +: 4] == FN_REV) ||
         (s.s2[1] && s.ctrl[C_FN2 +: 4] == FN_REV);
    if (!term) begin
      ff = s.ctrl[C_SWRUN] && !s.ctrl[C_SWREV];
      rr = s.ctrl[C_SWRUN] && s.ctrl[C_SWREV];
    end
    n.fwd = ff && !rr;
    n.rev = rr && !ff;
    tgt = (s.fwd || s.rev) ? int'(s.fref) : 0;

    // Control period
    rated = int'(s.motor[11:0]);
    nl    = rated * int'(s.motor[18:12]) / 100;
    if (s.ctrl[C_METH +: 4] == 4'h0 && s.fout >= s.fmin && !regen_active &&
        rated != 0 && int'(s.i_s) > nl) begin
      slip_tgt = int'(s.motor[31:24]) * int'(s.motor[23:19]) *
                 (int'(s.i_s) - nl) / (10 * (rated - nl));
    end
    if (tick) begin
      n.i_s = output_current;
      pct   = int'(s.i_s) * 100 / INV_RATED;
      alim  = lowered(s.acc_lim, s.fvmax, s.fout);
      rlim  = s.ctrl[C_AUTO] ? lowered(s.run_lim, s.fvmax, s.fout) : int'(s.run_lim);
      if (s.acc_lim >= LIM_OFF) begin
        n.acc_hold = 1'b0;
      end else if (pct > alim) begin
        n.acc_hold = 1'b1;
      end else if (pct + HYST_PCT <= alim) begin
        n.acc_hold = 1'b0;
      end
      if (s.run_lim < LIM_OFF && pct > rlim &&
          (s.run_stall || (int'(s.fout) == tgt && tgt != 0))) begin
        if (s.stall_cnt < 8'(STALL_PERIODS)) begin
          n.stall_cnt = s.stall_cnt + 8'h01;
        end else begin
          n.run_stall = 1'b1;
        end
      end else begin
        n.stall_cnt = 8'h00;
        n.run_stall = 1'b0;
      end
      set2 = s.ctrl[C_TSET2] || (s.run_stall && s.ctrl[C_RSEL]);
      ast  = rstep(s.fmax, set2 ? s.ramp[23:16] : s.ramp[7:0]);
      dst  = rstep(s.fmax, set2 ? s.ramp[31:24] : s.ramp[15:8]);
      if (s.run_stall) begin
        n.fout = (int'(s.fout) > dst) ? 16'(int'(s.fout) - dst) : 16'h0000;
      end else if (int'(s.fout) < tgt) begin
        if (!s.acc_hold) begin
          n.fout = (int'(s.fout) + ast > tgt) ? 16'(tgt) : 16'(int'(s.fout) + ast);
        end
      end else if (int'(s.fout) > tgt) begin
        if (s.ctrl[C_DSTL] || int'(dc_bus_voltage) <= DC_STALL_V) begin
          n.fout = (int'(s.fout) - dst < tgt) ? 16'(tgt) : 16'(int'(s.fout) - dst);
        end
      end
      tcn = ((s.slip_tc == 8'h00) ? SLIP_TC_ZERO : int'(s.slip_tc)) * PER_TENTH_S;
      // Filter holds comp times tcn, so small slips still settle
      c = int'(s.slip_acc);
      c = c + ((slip_tgt > 65535) ? 65535 : slip_tgt) - c / tcn;
      n.slip_acc = 32'(c);
      c = c / tcn;
      n.comp = 16'(c);
      c = int'(n.fout) + c;
      n.fcmd = (c > 65535) ? 16'hFFFF : 16'(c);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s         <= '0;
      s.ctrl    <= CTRL_RST;
      s.pscale  <= PSCALE_RST;
      s.acc_lim <= ACC_LIM_RST;
      s.run_lim <= RUN_LIM_RST;
      s.fmax    <= FMAX_RST;
      s.fvmax   <= FVMAX_RST;
      s.fmin    <= FMIN_RST;
      s.gain    <= GAIN_RST;
      s.ramp    <= RAMP_RST;
      s.slip_tc <= SLIPTC_RST;
    end else begin
      s <= n;
    end
  end

  assign awready  = wr_go;
  assign wready   = wr_go;
  assign bvalid   = s.bvalid;
  assign bresp    = s.bresp;
  assign arready  = !s.rvalid;
  assign rvalid   = s.rvalid;
  assign rdata    = s.rdata;
  assign rresp    = s.rresp;
  assign freq_cmd = s.fcmd;
  assign run_fwd  = s.fwd;
  assign run_rev  = s.rev;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_pscale_range: assert property (s.pscale >= PSCALE_MIN && s.pscale <= PSCALE_MAX)
    else $error("pulse scale out of range");
  a_limit_rst_vals: assert property ($rose(aresetn) |->
    s.acc_lim == ACC_LIM_RST && s.run_lim == RUN_LIM_RST)
    else $error("limit reset values wrong");
  a_acc_limit_off: assert property (tick && s.acc_lim >= LIM_OFF |=> !s.acc_hold)
    else $error("accel hold with limit off");
  a_acc_freeze: assert property (tick && s.acc_hold && !s.run_stall &&
    int'(s.fout) < tgt_q |=> $stable(s.fout))
    else $error("frequency moved while held");
  a_stall_after_wait: assert property ($rose(s.run_stall) |->
    $past(s.stall_cnt) == 8'(STALL_PERIODS))
    else $error("run stall came early");
  a_stall_decel: assert property (tick && s.run_stall && s.fout != 16'h0000 |=>
    s.fout < $past(s.fout))
    else $error("no decel during run stall");
  a_slip_gate: assert property ((s.ctrl[C_METH +: 4] != 4'h0 || regen_active ||
    s.motor[11:0] == 12'h000 || s.fout < s.fmin) |-> slip_tgt == 0)
    else $error("slip target while inhibited");
  a_i020_ref: assert property (s.ctrl[C_SRC +: 4] == SRC_I020 |->
    raw_ref == int'(analog_ref_terminal) * int'(s.fmax) / ADC_FULL)
    else $error("0-20 mA scaling wrong");
  a_term_run: assert property (s.ctrl[C_RUNS +: 2] == RUN_TERM &&
    s.ctrl[C_FN1 +: 4] == FN_FWD && s.ctrl[C_FN2 +: 4] == FN_REV &&
    s.s1[1] && !s.s2[1] |=> run_fwd && !run_rev)
    else $error("terminal forward not taken");
  a_bvalid_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");

  c_acc_hold: cover property ($rose(s.acc_hold));
  c_run_stall: cover property ($rose(s.run_stall));
  c_slip: cover property (tick && slip_tgt > 0);
  c_pulse_src: cover property (s.ctrl[C_SRC +: 4] == SRC_PULSE && pcount != 12'h000);

  assign tgt_q = (s.fwd || s.rev) ? int'(s.fref) : 0;
endmodule
`default_nettype wire

// [tb/ifc_motor_model.sv]
// Motor and power stage model: load current and bus voltage
`timescale 1ns/100ps
`default_nettype none
module ifc_motor_model (
  // Clock
  input  wire logic        aclk,
  // Load set by the bench, 0.1 A units
  input  wire logic [11:0] load,
  input  wire logic        regen,
  // Measurements to the drive
  output logic [11:0]      output_current = 12'h000,
  output logic [11:0]      dc_bus_voltage = 12'h12C,
  output logic             regen_active   = 1'b0
);
  // Bus rises while the motor feeds energy back
  always_ff @(posedge aclk) begin
    output_current <= load;
    dc_bus_voltage <= regen ? 12'h190 : 12'h12C;
    regen_active   <= regen;
  end
endmodule
`default_nettype wire

// [tb/ifc_freq_cmd_bench.sv]
// Bench for the frequency command block
`timescale 1ns/100ps
`default_nettype none
module ifc_freq_cmd_bench
  import ifc_pkg::*;
;
  localparam int TK = 20;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, in_one = 1'b0, in_two = 1'b0, pulse = 1'b0;
  logic        regen = 1'b0, pulse_en = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rb;
  logic [3:0]  wstrb = 4'h0;
  logic [11:0] adc = 12'h000, load = 12'h000;
  logic        awready, wready, bvalid, arready, rvalid, run_fwd, run_rev, regen_active;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata;
  logic [15:0] freq_cmd, f1;
  logic [11:0] output_current, dc_bus_voltage;
  logic [3:0]  src_t [4] = '{SRC_I020, SRC_I420, SRC_I420, SRC_I420};
  logic [11:0] adc_t [4] = '{12'hFFF, 12'h333, 12'hFFF, 12'hFFF};
  logic [9:0]  gn_t  [4] = '{10'h064, 10'h064, 10'h064, 10'h032};
  logic [15:0] ex_t  [4] = '{16'h0258, 16'h0000, 16'h0258, 16'h012C};
  int          bad_count = 0, cmp_count = 0;

  ifc_freq_cmd #(.CTRL_TICKS(TK), .GATE_TICKS(100)) u_ifc_freq_cmd (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .analog_ref_terminal(adc), .multifunction_input_one(in_one),
    .multifunction_input_two(in_two), .pulse_train_in(pulse),
    .output_current(output_current), .dc_bus_voltage(dc_bus_voltage),
    .regen_active(regen_active), .freq_cmd(freq_cmd), .run_fwd(run_fwd), .run_rev(run_rev));

  ifc_motor_model u_ifc_motor_model (
    .aclk(aclk), .load(load), .regen(regen), .output_current(output_current),
    .dc_bus_voltage(dc_bus_voltage), .regen_active(regen_active));

  // ----------------------------------------------------------------
  // Clock, pulse source, watchdog
  // ----------------------------------------------------------------
  initial begin
    forever #20 aclk = ~aclk;
  end

  // One rising edge every two cycles
  always @(posedge aclk) begin
    if (pulse_en) pulse <= ~pulse;
  end

  initial begin
    repeat (100000) @(posedge aclk);
    bad_count++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      cmp_count++;
      if (got !== exp) begin
        bad_count++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // Waits for a ready or valid: 0 awready, 1 bvalid, 2 arready, 3 rvalid
  task automatic wt(input int s);
    int   n;
    logic h;
    begin
      n = 0;
      h = 1'b0;
      while (h !== 1'b1) begin
        @(negedge aclk);
        h = (s == 0) ? awready : (s == 1) ? bvalid : (s == 2) ? arready : rvalid;
        rb = rdata;
        rs = (s == 1) ? bresp : rresp;
        @(posedge aclk);
        n++;
        if (n > 100) begin
          bad_count++;
          complete_run();
        end
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    begin
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hF;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      wt(0);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      wt(1);
      bready  <= 1'b0;
      @(posedge aclk);
    end
  endtask

  task automatic rd(input logic [7:0] a);
    begin
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      wt(2);
      arvalid <= 1'b0;
      wt(3);
      rready  <= 1'b0;
      @(posedge aclk);
    end
  endtask

  task automatic ticks(input int n);
    begin
      repeat (n * TK) @(posedge aclk);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ADDR_CTRL);   chk(rb, 32'h00021001);
    rd(ADDR_PSCALE); chk(rb, 32'h000009C4);
    rd(ADDR_LIMIT);  chk(rb, 32'h0000A0AA);
    rd(ADDR_SLIPTC); chk(rb, 32'h00000014);
    rd(8'h30);       chk(rb, 32'h0);
    chk(rs, RESP_ERR);
    wr(8'h30, 32'h1);  chk(rs, RESP_ERR);
    wr(ADDR_PSCALE, 32'h063); rd(ADDR_PSCALE); chk(rb, 32'h9C4);
    wr(ADDR_PSCALE, 32'hCE4); rd(ADDR_PSCALE); chk(rb, 32'hCE4);
    wr(ADDR_PSCALE, 32'hCE5); rd(ADDR_PSCALE); chk(rb, 32'hCE4);
    wr(ADDR_LIMIT, 32'hD2D2); rd(ADDR_LIMIT); chk(rb, 32'hC8C8);
    wr(ADDR_LIMIT, 32'hA0AA);
    // Current loop spans and gain
    for (int i = 0; i < 4; i++) begin
      adc <= adc_t[i];
      wr(ADDR_ADJ, {22'h0, gn_t[i]});
      wr(ADDR_CTRL, {8'h00, CTRL_RST[23:4], src_t[i]});
      ticks(3);
      rd(ADDR_REFOUT);
      chk(rb[15:0], ex_t[i]);
    end
    // Pulse train: 50 edges per gate, scale 100
    wr(ADDR_ADJ, 32'h064);
    wr(ADDR_PSCALE, 32'h064);
    pulse_en <= 1'b1;
    wr(ADDR_CTRL, {8'h00, CTRL_RST[23:4], SRC_PULSE});
    ticks(20);
    rd(ADDR_REFOUT); chk(rb[15:0], 16'h012C);
    pulse_en <= 1'b0;
    // Terminal run and acceleration hold
    wr(ADDR_CTRL, 32'h00121004);
    wr(ADDR_RAMP, 32'h01010101);
    load <= 12'h064;
    in_one <= 1'b1;
    repeat (5) @(posedge aclk);
    chk({run_fwd, run_rev}, 2'b10);
    in_one <= 1'b0;
    in_two <= 1'b1;
    repeat (5) @(posedge aclk);
    chk({run_fwd, run_rev}, 2'b01);
    in_two <= 1'b0;
    in_one <= 1'b1;
    ticks(10);
    load <= 12'h0B4;
    ticks(3);
    rd(ADDR_STAT); chk(rb[17], 1'b1);
    f1 = rb[15:0];
    ticks(5);
    rd(ADDR_STAT); chk(rb[15:0], f1);
    load <= 12'h0A6;
    ticks(3);
    rd(ADDR_STAT); chk(rb[17], 1'b1);
    load <= 12'h0A0;
    ticks(3);
    rd(ADDR_STAT); chk(rb[17], 1'b0);
    wr(ADDR_LIMIT, 32'hA0C8);
    load <= 12'h0FA;
    ticks(3);
    rd(ADDR_STAT); chk(rb[17], 1'b0);
    wr(ADDR_LIMIT, 32'hA0AA);
    load <= 12'h064;
    ticks(120);
    rd(ADDR_STAT); chk(rb[15:0], 16'h0258);
    rd(ADDR_REFOUT); chk(rb[31:16], 16'h0);
    // Running stall after 100 ms over the limit
    load <= 12'h0AA;
    ticks(95);
    rd(ADDR_STAT); chk(rb[18], 1'b0);
    ticks(10);
    rd(ADDR_STAT); chk(rb[18], 1'b1);
    load <= 12'h064;
    ticks(3);
    rd(ADDR_STAT); chk(rb[18], 1'b0);
    // Slip compensation, then regeneration with decel stall
    wr(ADDR_SLIPTC, 32'h01);
    wr(ADDR_MOTOR, 32'h32500064);
    ticks(600);
    rd(ADDR_REFOUT); chk(rb[31:16], 16'h0032);
    chk(freq_cmd, 16'h028A);
    regen <= 1'b1;
    wr(ADDR_ADJ, 32'h032);
    ticks(600);
    rd(ADDR_STAT); chk(rb[15:0], 16'h0258);
    rd(ADDR_REFOUT); chk(rb[31:16], 16'h0000);
    wr(ADDR_CTRL, 32'h00121104);
    ticks(60);
    chk(freq_cmd, 16'h012C);
    complete_run();
  end
endmodule
`default_nettype wire
